/* power_seq_pkg.sv */
// constants, timing and state codes for the module power-on sequencer
package power_seq_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000; // system clock rate
  localparam int TICK_MS = 1; // timer resolution in milliseconds
  // cycles per timer tick, derived from rate and tick length
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int POWER_ON_HOLD_S = 1; // least low time of the request pad
  localparam int BOOT_S = 10; // internal boot length
  localparam int ACTIVATE_S = 15; // least time from monitor high to activation
  // the same times in timer ticks
  localparam int POWER_ON_HOLD_TICKS = POWER_ON_HOLD_S * 1000 / TICK_MS;
  localparam int BOOT_TICKS = BOOT_S * 1000 / TICK_MS;
  localparam int ACTIVATE_TICKS = ACTIVATE_S * 1000 / TICK_MS;
  localparam int ELAPSED_W = 16; // width of the tick counter

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'h0, // unpowered, watching the request pad
    ST_PRESS = 3'h1, // request pad held low, measuring hold
    ST_BOOT = 3'h2, // initialization, boot running
    ST_SETTLE = 3'h3, // boot finished, waiting for activation
    ST_ACTIVE = 3'h4 // activation, commands accepted
  } seq_state_e;

endpackage : power_seq_pkg

/* tick_if.sv */
// carrier between the sequencer and its elapsed-time counter
`timescale 1ns/10ps
interface tick_if #(
  parameter int W = 16
);
  logic clear; // restart the count from zero
  logic [W-1:0] elapsed; // whole ticks since the last clear, saturating

  // the sequencer restarts and reads the count
  modport user (output clear, input elapsed);
  // the counter serves the sequencer
  modport timer (input clear, output elapsed);
endinterface : tick_if

/* tick_timer.sv */
// clock divider and saturating tick counter
`timescale 1ns/10ps
module tick_timer #(
  parameter int TICK_CYCLES = power_seq_pkg::TICK_CYCLES,
  parameter int W = power_seq_pkg::ELAPSED_W
) (
  input wire logic clk,
  input wire logic rst,
  tick_if.timer t
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (TICK_CYCLES < 1)
  begin : g_bad_tick
    $error("tick length must be at least one cycle");
  end

  localparam int DW = $clog2(TICK_CYCLES + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);
  localparam logic [W-1:0] CNT_MAX = {W{1'b1}};

  logic [DW-1:0] div_q, div_d; // cycles within the current tick
  logic [W-1:0] cnt_q, cnt_d; // whole ticks elapsed

  // ------------------------------------------------------------
  // next count
  // ------------------------------------------------------------
  // saturation keeps long waits from wrapping back to small values
  always_comb
  begin
    div_d = div_q;
    cnt_d = cnt_q;
    if (t.clear)
    begin
      div_d = '0;
      cnt_d = '0;
    end
    else if (div_q == DIV_LAST)
    begin
      // one-cycle tick enable
      div_d = '0;
      if (cnt_q != CNT_MAX)
        cnt_d = cnt_q + W'(1);
    end
    else
      div_d = div_q + DW'(1);
  end

  // registers only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      div_q <= div_d;
      cnt_q <= cnt_d;
    end
  end

  assign t.elapsed = cnt_q;

endmodule : tick_timer

/* power_on_sequencer.sv */
// power-on, boot and activation sequencer of the modem module
`timescale 1ns/10ps
module power_on_sequencer #(
  parameter int TICK_CYCLES = power_seq_pkg::TICK_CYCLES,
  parameter int HOLD_TICKS = power_seq_pkg::POWER_ON_HOLD_TICKS,
  parameter int BOOT_TICKS = power_seq_pkg::BOOT_TICKS,
  parameter int ACT_TICKS = power_seq_pkg::ACTIVATE_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_on_req_n, // request pad, low = pressed
  input wire logic dtr_present, // DTR line connected and asserted
  input wire logic sleep_req, // firmware asks for power saving
  input wire logic rts_n, // request to send, low = send allowed
  input wire logic incoming_call, // call arriving
  input wire logic at_cmd_req, // one-cycle command strobe
  output logic power_on_monitor,
  output logic aux_supply_power_indicator,
  output logic boot_done_indicator,
  output logic activated,
  output logic at_cmd_ack,
  output logic at_cmd_nak,
  output logic ri_n,
  output logic power_save,
  output logic tx_allowed
);

  localparam int W = power_seq_pkg::ELAPSED_W;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (HOLD_TICKS < 1 || BOOT_TICKS < 1 || ACT_TICKS <= BOOT_TICKS ||
      ACT_TICKS >= (1 << W))
  begin : g_bad_times
    $error("timing parameters out of range");
  end

  localparam logic [W-1:0] HOLD_T = W'(HOLD_TICKS);
  localparam logic [W-1:0] BOOT_T = W'(BOOT_TICKS);
  localparam logic [W-1:0] ACT_T = W'(ACT_TICKS);

  tick_if #(.W(W)) tk ();

  // elapsed ticks since the last restart
  tick_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .W(W)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .t(tk)
  );

  power_seq_pkg::seq_state_e state_q, state_d; // sequence state
  logic mon_q, mon_d; // power-on monitor
  logic boot_q, boot_d; // boot done
  logic act_q, act_d; // activation reached
  logic ack_q, ack_d; // command accepted pulse
  logic nak_q, nak_d; // command refused pulse
  logic ri_n_q, ri_n_d; // ring indicator, low = ringing
  logic save_q, save_d; // power saving entered
  logic tx_q, tx_d; // transmit allowed

  // ------------------------------------------------------------
  // state decode
  // ------------------------------------------------------------
  // activation decode shared by every gated output
  function automatic logic active_f(input power_seq_pkg::seq_state_e s);
    return s == power_seq_pkg::ST_ACTIVE;
  endfunction : active_f

  // ------------------------------------------------------------
  // sequence next state
  // ------------------------------------------------------------
  // the counter is restarted while off and at the monitor rise, so it
  // measures first the hold time and then time since power-up
  always_comb
  begin
    state_d = state_q;
    tk.clear = 1'b0;
    case (state_q)
      power_seq_pkg::ST_OFF:
      begin
        tk.clear = 1'b1;
        if (!power_on_req_n)
          state_d = power_seq_pkg::ST_PRESS;
      end
      power_seq_pkg::ST_PRESS:
      begin
        if (power_on_req_n)
        begin
          tk.clear = 1'b1;
          // a short press is ignored and the module stays off
          if (tk.elapsed >= HOLD_T)
            state_d = power_seq_pkg::ST_BOOT;
          else
            state_d = power_seq_pkg::ST_OFF;
        end
      end
      power_seq_pkg::ST_BOOT:
      begin
        if (tk.elapsed >= BOOT_T)
          state_d = power_seq_pkg::ST_SETTLE;
      end
      power_seq_pkg::ST_SETTLE:
      begin
        if (tk.elapsed >= ACT_T)
          state_d = power_seq_pkg::ST_ACTIVE;
      end
      power_seq_pkg::ST_ACTIVE:
      begin
        // shutdown is handled elsewhere; further presses are ignored
        state_d = state_q;
      end
      default:
        state_d = power_seq_pkg::ST_OFF;
    endcase
  end

  // ------------------------------------------------------------
  // output next values
  // ------------------------------------------------------------
  // monitor, boot and activation flops follow the next state so they agree with state_q; the other flops use state_q
  always_comb
  begin
    mon_d = (state_d == power_seq_pkg::ST_BOOT) ||
            (state_d == power_seq_pkg::ST_SETTLE) ||
            (state_d == power_seq_pkg::ST_ACTIVE);
    boot_d = (state_d == power_seq_pkg::ST_SETTLE) ||
             (state_d == power_seq_pkg::ST_ACTIVE);
    act_d = active_f(state_d);
    ack_d = at_cmd_req && active_f(state_q);
    nak_d = at_cmd_req && !active_f(state_q);
    ri_n_d = !(incoming_call && active_f(state_q));
    save_d = sleep_req && dtr_present && active_f(state_q);
    tx_d = !rts_n && active_f(state_q);
  end

  // registers only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= power_seq_pkg::ST_OFF;
      mon_q <= 1'b0;
      boot_q <= 1'b0;
      act_q <= 1'b0;
      ack_q <= 1'b0;
      nak_q <= 1'b0;
      ri_n_q <= 1'b1;
      save_q <= 1'b0;
      tx_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mon_q <= mon_d;
      boot_q <= boot_d;
      act_q <= act_d;
      ack_q <= ack_d;
      nak_q <= nak_d;
      ri_n_q <= ri_n_d;
      save_q <= save_d;
      tx_q <= tx_d;
    end
  end

  // ------------------------------------------------------------
  // output ports
  // ------------------------------------------------------------
  // aux supply mirrors monitor
  assign power_on_monitor = mon_q;
  assign aux_supply_power_indicator = mon_q;
  assign boot_done_indicator = boot_q;
  assign activated = act_q;
  assign at_cmd_ack = ack_q;
  assign at_cmd_nak = nak_q;
  assign ri_n = ri_n_q;
  assign power_save = save_q;
  assign tx_allowed = tx_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_power_up;
    @(posedge clk) disable iff (rst)
    $rose(mon_q) |-> $past(state_q) == power_seq_pkg::ST_PRESS && $past(power_on_req_n);
  endproperty
  a_power_up: assert property (p_power_up) else $error("power-up without held press");

  property p_boot_len;
    @(posedge clk) disable iff (rst)
    $rose(boot_q) |-> tk.elapsed >= BOOT_T && mon_q;
  endproperty
  a_boot_len: assert property (p_boot_len) else $error("boot ended early");

  property p_act_delay;
    @(posedge clk) disable iff (rst)
    $rose(act_q) |-> tk.elapsed >= ACT_T && boot_q;
  endproperty
  a_act_delay: assert property (p_act_delay) else $error("activation too early");

  property p_no_cmd;
    @(posedge clk) disable iff (rst)
    at_cmd_req && !act_q |=> nak_q && !ack_q;
  endproperty
  a_no_cmd: assert property (p_no_cmd) else $error("command taken before activation");

  property p_cmd_ok;
    @(posedge clk) disable iff (rst)
    at_cmd_req && act_q |=> ack_q && !nak_q;
  endproperty
  a_cmd_ok: assert property (p_cmd_ok) else $error("command refused when active");

  property p_monitor;
    @(posedge clk) disable iff (rst)
    mon_q == (state_q != power_seq_pkg::ST_OFF && state_q != power_seq_pkg::ST_PRESS);
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor disagrees with state");

  property p_save;
    @(posedge clk) disable iff (rst)
    save_q |-> $past(dtr_present) && act_q;
  endproperty
  a_save: assert property (p_save) else $error("power saving without DTR");

  property p_ring;
    @(posedge clk) disable iff (rst)
    incoming_call && act_q |=> !ri_n_q;
  endproperty
  a_ring: assert property (p_ring) else $error("ring not signalled");

  property p_aux;
    @(posedge clk) disable iff (rst)
    aux_supply_power_indicator == (state_q != power_seq_pkg::ST_OFF &&
                                   state_q != power_seq_pkg::ST_PRESS);
  endproperty
  a_aux: assert property (p_aux) else $error("aux supply differs from monitor");

  property p_boot_pwr;
    @(posedge clk) disable iff (rst)
    boot_q |-> mon_q;
  endproperty
  a_boot_pwr: assert property (p_boot_pwr) else $error("boot done while unpowered");

  c_power_up: cover property (@(posedge clk) disable iff (rst) $rose(mon_q));
  c_short_press: cover property (@(posedge clk) disable iff (rst)
    state_q == power_seq_pkg::ST_PRESS ##1 state_q == power_seq_pkg::ST_OFF);
  c_active: cover property (@(posedge clk) disable iff (rst) $rose(act_q));
  c_cmd: cover property (@(posedge clk) disable iff (rst) ack_q);

endmodule : power_on_sequencer

/* host_model.sv */
// host side model that pulses the open-collector power-on request pad
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  input wire logic power_on_monitor, // module power state as seen by the host
  input wire logic press_go, // bench asks for one press
  input wire logic [15:0] press_len, // cycles to hold the pad low
  output wire logic power_on_req_n // pad level after the internal pull-up
);
  // ------------------------------------------------------------
  // pad driver
  // ------------------------------------------------------------
  logic pad_low; // high while the host sinks the pad

  // open collector only
  // no totem pole: released pad reads the internal pull-up level
  assign power_on_req_n = pad_low ? 1'b0 : 1'b1;

  // one press per request while the monitor is not high, changes just after the clock edge
  initial
  begin
    pad_low = 1'b0;
    forever
    begin
      @(posedge clk iff press_go);
      #1;
      if (power_on_monitor !== 1'b1)
      begin
        pad_low = 1'b1;
        repeat (press_len) @(posedge clk);
        #1;
      end
      pad_low = 1'b0;
    end
  end
endmodule : host_model

/* test_power_on_sequencer.sv */
// self-checking bench for the power-on sequencer
`timescale 1ns/10ps
module test_power_on_sequencer;
  // ------------------------------------------------------------
  // shortened timing so a full boot takes tens of cycles
  // ------------------------------------------------------------
  localparam int TC = 2; // cycles per tick
  localparam int HT = 4; // hold ticks
  localparam int BT = 6; // boot ticks
  localparam int AT = 10; // activation ticks
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic press_go = 1'b0;
  logic [15:0] press_len = 16'h0000;
  logic dtr_present = 1'b0; // host outputs low while module off
  logic sleep_req = 1'b0;
  logic rts_n = 1'b0;
  logic incoming_call = 1'b0;
  logic at_cmd_req = 1'b0;
  wire logic power_on_req_n;
  logic power_on_monitor, aux_supply_power_indicator, boot_done_indicator, activated;
  logic at_cmd_ack, at_cmd_nak, ri_n, power_save, tx_allowed;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0; // watchdog count
  int n, b;

  power_on_sequencer #(.TICK_CYCLES(TC), .HOLD_TICKS(HT), .BOOT_TICKS(BT), .ACT_TICKS(AT))
    i_dut (.clk(clk), .rst(rst), .power_on_req_n(power_on_req_n),
    .dtr_present(dtr_present), .sleep_req(sleep_req), .rts_n(rts_n),
    .incoming_call(incoming_call), .at_cmd_req(at_cmd_req),
    .power_on_monitor(power_on_monitor), .aux_supply_power_indicator(aux_supply_power_indicator),
    .boot_done_indicator(boot_done_indicator), .activated(activated),
    .at_cmd_ack(at_cmd_ack), .at_cmd_nak(at_cmd_nak), .ri_n(ri_n),
    .power_save(power_save), .tx_allowed(tx_allowed));

  host_model i_host (.clk(clk), .power_on_monitor(power_on_monitor), .press_go(press_go),
    .press_len(press_len), .power_on_req_n(power_on_req_n));

  // ------------------------------------------------------------
  // clock, watchdog and helpers
  // ------------------------------------------------------------
  initial
  begin
    forever #5 clk = ~clk;
  end

  // a hang counts as a mismatch; whole run needs well under 1000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  // one request pulse to the host model, held across one edge
  task automatic press(input int len);
    press_len = len[15:0];
    press_go = 1'b1;
    step(1);
    press_go = 1'b0;
  endtask : press

  task automatic cmd_once();
    at_cmd_req = 1'b1;
    step(1);
    at_cmd_req = 1'b0;
  endtask : cmd_once

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk({power_on_monitor, aux_supply_power_indicator, boot_done_indicator, activated}, 16'h0);
    chk(ri_n, 1'b1);
  endtask : t_reset

  // short press is ignored, commands while off are refused
  task automatic t_short();
    press(HT * TC - 3);
    step(HT * TC + 10);
    chk(power_on_monitor, 1'b0);
    chk({ri_n, power_save, tx_allowed}, 16'h4);
    cmd_once();
    chk({at_cmd_ack, at_cmd_nak}, 16'h1);
  endtask : t_short

  // full press, boot and activation timing counted from monitor rise
  task automatic t_power();
    press(HT * TC + 4);
    n = 0;
    while (power_on_monitor !== 1'b1 && n < 60)
    begin
      step(1);
      n++;
    end
    chk(power_on_monitor, 1'b1);
    chk(aux_supply_power_indicator, 1'b1);
    incoming_call = 1'b1;
    cmd_once();
    chk({at_cmd_ack, at_cmd_nak}, 16'h1);
    chk(ri_n, 1'b1);
    incoming_call = 1'b0;
    n = 1;
    b = -1;
    while (activated !== 1'b1 && n < 200)
    begin
      step(1);
      n++;
      if (b < 0 && boot_done_indicator === 1'b1)
        b = n;
    end
    chk(b >= BT * TC && b <= BT * TC + TC + 2, 1'b1);
    chk(n >= AT * TC && n <= AT * TC + TC + 2, 1'b1);
  endtask : t_power

  // commands back to back, ring, power saving and send permission
  task automatic t_active();
    at_cmd_req = 1'b1;
    step(1);
    chk({at_cmd_ack, at_cmd_nak}, 16'h2);
    step(1);
    at_cmd_req = 1'b0;
    chk({at_cmd_ack, at_cmd_nak}, 16'h2);
    step(1);
    chk({at_cmd_ack, at_cmd_nak}, 16'h0);
    incoming_call = 1'b1;
    step(1);
    chk(ri_n, 1'b0);
    incoming_call = 1'b0;
    sleep_req = 1'b1;
    step(1);
    chk({ri_n, power_save}, 16'h2);
    dtr_present = 1'b1;
    step(1);
    chk(power_save, 1'b1);
    rts_n = 1'b1;
    step(1);
    chk(tx_allowed, 1'b0);
    rts_n = 1'b0;
    step(1);
    chk(tx_allowed, 1'b1);
    press(HT * TC + 4);
    step(HT * TC + 10);
    chk({power_on_monitor, activated}, 16'h3);
  endtask : t_active

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    step(4);
    rst = 1'b0;
    t_reset();
    t_short();
    t_power();
    t_active();
    end_sim();
  end
endmodule : test_power_on_sequencer
